//--- sdma_consts.vh
// Constants for the serial-port DMA engine
`ifndef SDMA_CONSTS_VH
`define SDMA_CONSTS_VH

// Register byte addresses
`define SDMA_ADDR_W          12
`define SDMA_OFS_CTRL2       12'hF86
`define SDMA_OFS_CTRL1       12'hF88
`define SDMA_OFS_BC_LO       12'hF80
`define SDMA_OFS_BC_HI       12'hF81
`define SDMA_OFS_TX_LO       12'hF82
`define SDMA_OFS_TX_HI       12'hF83
`define SDMA_OFS_RX_LO       12'hF84
`define SDMA_OFS_RX_HI       12'hF85
`define SDMA_OFS_FLAG        12'hF87

// Reset values
`define SDMA_RST_BYTE        8'h00
`define SDMA_RST_BC          10'h000
`define SDMA_RST_PTR         12'h000

// Main control fields
`define SDMA_C1_ACTIVE       0
`define SDMA_C1_DLYIRQ       1
`define SDMA_C1_DIR_LO       2
`define SDMA_C1_DIR_HI       3
`define SDMA_DIR_FULL        2'h2
`define SDMA_DIR_TX          2'h1
`define SDMA_DIR_RX          2'h0

// Delay/watermark fields
`define SDMA_C2_WM_LO        0
`define SDMA_C2_WM_HI        3
`define SDMA_C2_DLY_LO       4
`define SDMA_C2_DLY_HI       7

// Delay decode
`define SDMA_DLY_POW_LAST    4'h7
`define SDMA_DLY_TOP         4'hF
`define SDMA_DLY_MAX         12'h800
`define SDMA_DLY_STEP        12'h080
`define SDMA_DLY_OFFS        4'h6

// Watermark decode
`define SDMA_WM_NONE         4'h0
`define SDMA_WM_POW_LAST     4'h6
`define SDMA_WM_ODD          4'h7
`define SDMA_WM_ODD_VAL      11'h043
`define SDMA_WM_STEP         11'h040
`define SDMA_WM_OFFS         4'h6

// Minimum master idle per serial clock divider
`define SDMA_DIV4            2'h0
`define SDMA_DIV16           2'h1
`define SDMA_IDLE_DIV4       12'h008
`define SDMA_IDLE_DIV16      12'h009
`define SDMA_IDLE_DIV64      12'h00F
`define SDMA_IRQ_DLY_GAP     12'h001

// Protected banks 14 and 15
`define SDMA_BANK_PROT       4'hE

// Dummy byte sent in receive-only mode
`define SDMA_DUMMY_TX        8'hFF

`endif

//--- sdma_spi_dma_engine.v
// Serial-port DMA engine: registers, memory mover and flag logic
// Function
// - Delay code maps to 1..2048 cycles
// - Delay adds to overhead when irq disabled
// - Master idles minimum cycles per clock divider
// - Irq enabled: timeout interrupt, short rewrite gap
// - Watermark code maps to remaining-byte thresholds
// - Ten-bit counter decrements after each byte but the last
// - Final byte clears active, counter reads zero
// - Transfers counter value plus one bytes
// - Transmit bytes fetched via advancing tx pointer
// - Transmit reads of banks 14/15 blocked
// - Received bytes stored via advancing rx pointer
// - Receive writes to banks 14/15 blocked
// - Flag sets when remaining count hits watermark
// - Flag sets when transaction completes
// - No watermark refire until completion or rewrite
// - Watermark rewrite above remaining sets flag
// - Slave timeout interrupt on long gap
// - Master and slave both start on active
// - Per-byte flag only when engine inactive
// - Software sets active bit, engine clears it
// - Direction code 10 full, 01 tx, 00 rx
// - Abort finishes byte, then stops all updates
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "sdma_consts.vh"
`default_nettype none

module sdma_spi_dma_engine #(
	parameter AW = `SDMA_ADDR_W
) (
	// Clock and reset
	input  wire          clk,
	input  wire          sys_rst,
	// Register port
	input  wire [AW-1:0] regAddr,
	input  wire [7:0]    regWrData,
	input  wire          regWrite,
	input  wire          regRead,
	output reg  [7:0]    regRdData,
	// Memory port
	output reg  [11:0]   memAddr,
	output reg           memRdReq,
	input  wire [7:0]    memRdData,
	output reg           memWrReq,
	output reg  [7:0]    memWrData,
	// Serial port side
	input  wire          sspMaster,
	input  wire [1:0]    sspClkDiv,
	output reg           sspWrite,
	output reg  [7:0]    sspTxData,
	input  wire          sspByteDone,
	input  wire [7:0]    sspRxData,
	// Status
	output reg           serialPortIrqFlag,
	output reg           transferActive
);

	localparam S_IDLE  = 3'h0;
	localparam S_FETCH = 3'h1;
	localparam S_FWAIT = 3'h2;
	localparam S_LOAD  = 3'h3;
	localparam S_WAITB = 3'h4;
	localparam S_UPD   = 3'h5;
	localparam S_GAP   = 3'h6;

	// Delay decode
	function [11:0] dlyCycles;
		input [3:0] code;
		begin
			if (code <= `SDMA_DLY_POW_LAST) begin
				dlyCycles = 12'h001 << code;
			end else if (code == `SDMA_DLY_TOP) begin
				dlyCycles = `SDMA_DLY_MAX;
			end else begin
				dlyCycles = {8'h00, code - `SDMA_DLY_OFFS} * `SDMA_DLY_STEP;
			end
		end
	endfunction

	// Watermark decode
	function [10:0] wmBytes;
		input [3:0] code;
		begin
			if (code == `SDMA_WM_NONE) begin
				wmBytes = 11'h000;
			end else if (code <= `SDMA_WM_POW_LAST) begin
				wmBytes = 11'h001 << (code - 4'h1);
			end else if (code == `SDMA_WM_ODD) begin
				wmBytes = `SDMA_WM_ODD_VAL;
			end else begin
				wmBytes = {7'h00, code - `SDMA_WM_OFFS} * `SDMA_WM_STEP;
			end
		end
	endfunction

	reg  [7:0]  mainCtrl;
	reg  [7:0]  delayWmCtrl;
	reg  [9:0]  byteCounter;
	reg  [11:0] txPointer;
	reg  [11:0] rxPointer;
	reg  [2:0]  state;
	reg  [11:0] gapCnt;
	reg  [11:0] idleCnt;
	reg         wmDone;
	reg         blockTx;

	wire [1:0]  dirSel    = mainCtrl[`SDMA_C1_DIR_HI:`SDMA_C1_DIR_LO];
	wire        dlyIrqEn  = mainCtrl[`SDMA_C1_DLYIRQ];
	wire [3:0]  dlySel    = delayWmCtrl[`SDMA_C2_DLY_HI:`SDMA_C2_DLY_LO];
	wire [3:0]  wmSel     = delayWmCtrl[`SDMA_C2_WM_HI:`SDMA_C2_WM_LO];
	// Direction decode
	wire        txUse     = (dirSel == `SDMA_DIR_FULL) || (dirSel == `SDMA_DIR_TX);
	wire        rxUse     = (dirSel == `SDMA_DIR_FULL) || (dirSel == `SDMA_DIR_RX);
	wire [11:0] dlyVal    = dlyCycles(dlySel);
	wire [10:0] remaining = {1'b0, byteCounter} + 11'h001;
	wire [10:0] wmVal     = wmBytes(wmSel);
	wire        txProt    = (txPointer[11:8] >= `SDMA_BANK_PROT);
	wire        rxProt    = (rxPointer[11:8] >= `SDMA_BANK_PROT);

	// Minimum master idle
	reg  [11:0] minIdle;
	always @* begin
		case (sspClkDiv)
			`SDMA_DIV4:  minIdle = `SDMA_IDLE_DIV4;
			`SDMA_DIV16: minIdle = `SDMA_IDLE_DIV16;
			default:     minIdle = `SDMA_IDLE_DIV64;
		endcase
	end
	// Gap: minimum idle plus selected delay, or plus one cycle when the delay irq is on
	wire [11:0] gapTarget = minIdle + (dlyIrqEn ? `SDMA_IRQ_DLY_GAP : dlyVal);
	wire        gapDone   = (gapCnt >= gapTarget - 12'h001);
	wire [2:0]  firstState = txUse ? S_FETCH : S_LOAD;

	wire wrCtrl1 = regWrite && (regAddr == `SDMA_OFS_CTRL1);
	wire wrCtrl2 = regWrite && (regAddr == `SDMA_OFS_CTRL2);
	wire wrFlag  = regWrite && (regAddr == `SDMA_OFS_FLAG);
	// Register write decodes for counter and pointers
	wire wrBcLo  = regWrite && (regAddr == `SDMA_OFS_BC_LO);
	wire wrBcHi  = regWrite && (regAddr == `SDMA_OFS_BC_HI);
	wire wrTxLo  = regWrite && (regAddr == `SDMA_OFS_TX_LO);
	wire wrTxHi  = regWrite && (regAddr == `SDMA_OFS_TX_HI);
	wire wrRxLo  = regWrite && (regAddr == `SDMA_OFS_RX_LO);
	wire wrRxHi  = regWrite && (regAddr == `SDMA_OFS_RX_HI);
	wire [10:0] newWm = wmBytes(regWrData[`SDMA_C2_WM_HI:`SDMA_C2_WM_LO]);
	wire wmRaise = wrCtrl2 && transferActive && (newWm > remaining);
	wire lastByte  = (state == S_UPD) && (byteCounter == `SDMA_RST_BC);
	wire finish    = transferActive && lastByte;
	wire wmHit     = transferActive && !wmDone && (wmVal != 11'h000)
		&& (remaining <= wmVal) && (state != S_IDLE);
	wire timeoutHit = transferActive && dlyIrqEn && (state != S_IDLE)
		&& (idleCnt == dlyVal);
	wire perByte    = sspByteDone && !transferActive && (state == S_IDLE);

	// Byte engine
	always @(posedge clk) begin
		if (sys_rst) begin
			state       <= S_IDLE;
			byteCounter <= `SDMA_RST_BC;
			txPointer   <= `SDMA_RST_PTR;
			rxPointer   <= `SDMA_RST_PTR;
			memAddr     <= `SDMA_RST_PTR;
			memRdReq    <= 1'b0;
			memWrReq    <= 1'b0;
			memWrData   <= `SDMA_RST_BYTE;
			sspWrite    <= 1'b0;
			sspTxData   <= `SDMA_RST_BYTE;
			gapCnt      <= 12'h000;
			blockTx     <= 1'b0;
		end else begin
			memRdReq <= 1'b0;
			memWrReq <= 1'b0;
			sspWrite <= 1'b0;
			if (wrBcLo) begin
				byteCounter[7:0] <= regWrData;
			end
			if (wrBcHi) begin
				byteCounter[9:8] <= regWrData[1:0];
			end
			if (wrTxLo) begin
				txPointer[7:0] <= regWrData;
			end
			if (wrTxHi) begin
				txPointer[11:8] <= regWrData[3:0];
			end
			if (wrRxLo) begin
				rxPointer[7:0] <= regWrData;
			end
			if (wrRxHi) begin
				rxPointer[11:8] <= regWrData[3:0];
			end
			case (state)
				S_IDLE: begin
					// Arms in both modes; slave waits for the peer clock
					if (transferActive) begin
						state <= firstState;
					end
				end
				S_FETCH: begin
					if (!transferActive) begin
						state <= S_IDLE;
					end else begin
						memAddr  <= txPointer;
						memRdReq <= !txProt;
						blockTx  <= txProt;
						state    <= S_FWAIT;
					end
				end
				S_FWAIT: begin
					if (!transferActive) begin
						state <= S_IDLE;
					end else begin
						state <= S_LOAD;
					end
				end
				S_LOAD: begin
					if (!transferActive) begin
						state <= S_IDLE;
					end else begin
						// Data fetched first, then the shift buffer written
						sspWrite <= 1'b1;
						if (!txUse) begin
							sspTxData <= `SDMA_DUMMY_TX;
						end else if (blockTx) begin
							sspTxData <= `SDMA_RST_BYTE;
						end else begin
							sspTxData <= memRdData;
						end
						state <= S_WAITB;
					end
				end
				S_WAITB: begin
					if (sspByteDone) begin
						if (!transferActive) begin
							state <= S_IDLE;
						end else begin
							if (rxUse) begin
								memAddr   <= rxPointer;
								memWrData <= sspRxData;
								memWrReq  <= !rxProt;
							end
							state <= S_UPD;
						end
					end
				end
				S_UPD: begin
					if (!transferActive) begin
						// Aborted: pointers and counter stay as they are
						state <= S_IDLE;
					end else begin
						// Store issued last cycle, now count and advance
						if (txUse) begin
							txPointer <= txPointer + 12'h001;
						end
						if (rxUse) begin
							rxPointer <= rxPointer + 12'h001;
						end
						gapCnt <= 12'h000;
						if (byteCounter == `SDMA_RST_BC) begin
							state <= S_IDLE;
						end else begin
							byteCounter <= byteCounter - 10'h001;
							if (sspMaster) begin
								state <= S_GAP;
							end else begin
								state <= firstState;
							end
						end
					end
				end
				S_GAP: begin
					if (!transferActive) begin
						state <= S_IDLE;
					end else if (gapDone) begin
						state <= firstState;
					end else begin
						gapCnt <= gapCnt + 12'h001;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// Control registers and active bit
	always @(posedge clk) begin
		if (sys_rst) begin
			mainCtrl       <= `SDMA_RST_BYTE;
			delayWmCtrl    <= `SDMA_RST_BYTE;
			transferActive <= 1'b0;
		end else begin
			if (finish) begin
				transferActive <= 1'b0;
			end
			if (wrCtrl1) begin
				mainCtrl       <= regWrData;
				transferActive <= regWrData[`SDMA_C1_ACTIVE];
			end
			if (wrCtrl2) begin
				delayWmCtrl <= regWrData;
			end
		end
	end

	// Watermark latch and interrupt flag
	always @(posedge clk) begin
		if (sys_rst) begin
			wmDone            <= 1'b0;
			serialPortIrqFlag <= 1'b0;
		end else begin
			if (state == S_IDLE) begin
				wmDone <= 1'b0;
			end else if (wmRaise) begin
				wmDone <= 1'b1;
			end else if (wmHit) begin
				wmDone <= 1'b1;
			end
			// Hardware set wins over software clear
			if (wmHit || wmRaise || finish || timeoutHit || perByte) begin
				serialPortIrqFlag <= 1'b1;
			end else if (wrFlag) begin
				serialPortIrqFlag <= regWrData[0];
			end
		end
	end

	// Time since last completed byte
	always @(posedge clk) begin
		if (sys_rst) begin
			idleCnt <= 12'h000;
		end else if (sspByteDone || (state == S_IDLE)) begin
			idleCnt <= 12'h000;
		end else if (idleCnt <= dlyVal) begin
			idleCnt <= idleCnt + 12'h001;
		end
	end

	// Register read mux, zero when no read strobe
	reg  [7:0]  next_regRdData;
	always @* begin
		next_regRdData = `SDMA_RST_BYTE;
		if (regRead) begin
			case (regAddr)
				`SDMA_OFS_CTRL1: next_regRdData = {mainCtrl[7:1], transferActive};
				`SDMA_OFS_CTRL2: next_regRdData = delayWmCtrl;
				`SDMA_OFS_BC_LO: next_regRdData = byteCounter[7:0];
				`SDMA_OFS_BC_HI: next_regRdData = {6'h00, byteCounter[9:8]};
				`SDMA_OFS_TX_LO: next_regRdData = txPointer[7:0];
				`SDMA_OFS_TX_HI: next_regRdData = {4'h0, txPointer[11:8]};
				`SDMA_OFS_RX_LO: next_regRdData = rxPointer[7:0];
				`SDMA_OFS_RX_HI: next_regRdData = {4'h0, rxPointer[11:8]};
				`SDMA_OFS_FLAG:  next_regRdData = {7'h00, serialPortIrqFlag};
				default:         next_regRdData = `SDMA_RST_BYTE;
			endcase
		end
	end

	// Read data register, stands one cycle after the strobe
	always @(posedge clk) begin
		if (sys_rst) begin
			regRdData <= `SDMA_RST_BYTE;
		end else begin
			regRdData <= next_regRdData;
		end
	end

endmodule // sdma_spi_dma_engine
`default_nettype wire

//--- sdma_checker_assertions.sv
// Port assertions for the serial-port DMA engine
`timescale 1ns/10ps
`default_nettype none
module sdma_checker #(
	parameter AW = 12
) (
	// Clock and reset
	input wire logic          clk,
	input wire logic          sys_rst,
	// Register port
	input wire logic [AW-1:0] regAddr,
	input wire logic [7:0]    regWrData,
	input wire logic          regWrite,
	input wire logic          regRead,
	input wire logic [7:0]    regRdData,
	// Memory port
	input wire logic [11:0]   memAddr,
	input wire logic          memRdReq,
	input wire logic [7:0]    memRdData,
	input wire logic          memWrReq,
	input wire logic [7:0]    memWrData,
	// Serial port side
	input wire logic          sspMaster,
	input wire logic [1:0]    sspClkDiv,
	input wire logic          sspWrite,
	input wire logic [7:0]    sspTxData,
	input wire logic          sspByteDone,
	input wire logic [7:0]    sspRxData,
	// Status
	input wire logic          serialPortIrqFlag,
	input wire logic          transferActive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet; !sspWrite [*8]; endsequence
	sequence s_start; ##[1:3] (memRdReq || sspWrite); endsequence
	property p_fetch; memRdReq |-> ##2 sspWrite; endproperty
	a_fetch: assert property (p_fetch) else $error("no load after fetch");
	property p_txData; memRdReq |-> ##2 sspTxData == $past(memRdData); endproperty
	a_txData: assert property (p_txData) else $error("tx byte wrong");
	property p_bankR; memRdReq |-> memAddr[11:8] < 4'hE; endproperty
	a_bankR: assert property (p_bankR) else $error("read of top banks");
	property p_bankW; memWrReq |-> memAddr[11:8] < 4'hE; endproperty
	a_bankW: assert property (p_bankW) else $error("write to top banks");
	property p_store; memWrReq |-> $past(sspByteDone) && memWrData == $past(sspRxData); endproperty
	a_store: assert property (p_store) else $error("bad store");
	property p_busy; memRdReq || memWrReq |-> transferActive; endproperty
	a_busy: assert property (p_busy) else $error("memory access idle");
	property p_done;
		$fell(transferActive) && !$past(regWrite) && !$past(sys_rst) |-> serialPortIrqFlag;
	endproperty
	a_done: assert property (p_done) else $error("no completion flag");
	property p_gap; sspByteDone && sspMaster && sspClkDiv == 2'h0 |=> s_quiet; endproperty
	a_gap: assert property (p_gap) else $error("master gap short");
	property p_start; $rose(transferActive) && sspMaster |-> s_start; endproperty
	a_start: assert property (p_start) else $error("master did not start");
endmodule // sdma_checker
bind sdma_spi_dma_engine sdma_checker #(.AW(AW)) sdma_checker_i (.clk, .sys_rst, .regAddr,
	.regWrData, .regWrite, .regRead, .regRdData, .memAddr, .memRdReq, .memRdData, .memWrReq,
	.memWrData, .sspMaster, .sspClkDiv, .sspWrite, .sspTxData, .sspByteDone, .sspRxData,
	.serialPortIrqFlag, .transferActive);
`default_nettype wire

//--- sdma_spi_peer.sv
// Far-side serial peer: shifts each byte and answers
`timescale 1ns/10ps
`default_nettype none
module sdma_spi_peer (
	// Clock
	input  wire logic       clk,
	// Shift buffer side
	input  wire logic       sspWrite,
	input  wire logic [7:0] sspTxData,
	input  wire logic       hold,
	output var  logic       sspByteDone,
	output var  logic [7:0] sspRxData
);
	logic [7:0] shiftVal;
	int         left;
	initial begin
		sspByteDone = 1'b0;
		sspRxData = 8'h00;
		left = 0;
	end
	// Hold stalls the far clock; line toggles when not valid
	always @(posedge clk) begin
		sspByteDone <= 1'b0;
		sspRxData <= ~sspRxData;
		if (sspWrite) begin
			shiftVal <= sspTxData;
			left <= 6;
		end else if (left > 1 && !hold) begin
			left <= left - 1;
		end else if (left == 1 && !hold) begin
			left <= 0;
			sspByteDone <= 1'b1;
			sspRxData <= shiftVal ^ 8'h5A;
		end
	end
endmodule // sdma_spi_peer
`default_nettype wire

//--- sdma_tb.sv
// Self-checking testbench for the serial-port DMA engine
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, hold = 0, sspMaster = 1;
	logic [11:0] regAddr = 0, memAddr, tx, rx;
	logic [7:0]  regWrData = 0, regRdData, memRdData = 0, memWrData, sspTxData, sspRxData, r;
	logic [1:0]  sspClkDiv = 0;
	logic        memRdReq, memWrReq, sspWrite, sspByteDone, serialPortIrqFlag, transferActive;
	logic        rdPend = 0, ie = 0;
	logic [9:0]  n;
	logic [7:0]  mem [0:4095];
	logic [19:0] rq[$], wq[$];
	int          errors = 0, checks = 0, seed = 22, i, k;
	sdma_spi_dma_engine sdma_spi_dma_engine_i (.clk, .sys_rst, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .memAddr, .memRdReq, .memRdData, .memWrReq, .memWrData, .sspMaster,
		.sspClkDiv, .sspWrite, .sspTxData, .sspByteDone, .sspRxData, .serialPortIrqFlag,
		.transferActive);
	sdma_spi_peer sdma_spi_peer_i (.clk, .sspWrite, .sspTxData, .hold, .sspByteDone, .sspRxData);
	always #5 clk = ~clk;
	always @(posedge clk) memRdData <= memRdReq ? mem[memAddr] : ~memRdData;
	always @(posedge clk) begin
		if (rdPend) chk(20'(regRdData), rq.pop_front());
		rdPend <= regRead;
		if (memWrReq) chk({memAddr, memWrData}, wq.size() ? wq.pop_front() : 'x);
	end
	task chk(input logic [19:0] s, input logic [19:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		rq.push_back(20'(e));
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
	endtask
	task go(input logic [1:0] d, input logic [7:0] c2);
		logic [11:0] a;
		logic [7:0]  t;
		wr(12'hF80, n[7:0]);
		wr(12'hF81, {6'h00, n[9:8]});
		wr(12'hF82, tx[7:0]);
		wr(12'hF83, {4'h0, tx[11:8]});
		wr(12'hF84, rx[7:0]);
		wr(12'hF85, {4'h0, rx[11:8]});
		wr(12'hF86, c2);
		wr(12'hF87, 8'h00);
		for (int j = 0; j <= int'(n); j++) begin
			a = tx + 12'(j);
			t = (d == 2'h0) ? 8'hFF : (a[11:8] >= 4'hE) ? 8'h00 : mem[a];
			a = rx + 12'(j);
			if (d != 2'h1 && a[11:8] < 4'hE) wq.push_back({a, t ^ 8'h5A});
		end
		wr(12'hF88, {4'h0, d, ie, 1'b1});
	endtask
	task fin(input logic [1:0] d);
		for (k = 0; k < 5000 && transferActive !== 1'b0; k++) @(posedge clk);
		chk(20'(k < 5000), 20'h1);
		rd(12'hF80, 8'h00);
		rd(12'hF81, 8'h00);
		rd(12'hF87, 8'h01);
		rd(12'hF88, {4'h0, d, ie, 1'b0});
		if (d != 2'h0) rd(12'hF82, 8'(tx + 12'(n) + 12'h001));
		if (d != 2'h1) rd(12'hF84, 8'(rx + 12'(n) + 12'h001));
		chk(20'(wq.size()), 20'h0);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		end_of_test;
	end
	initial begin
		for (i = 0; i < 4096; i++) mem[i] = 8'($random(seed));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(12'hF86, 8'h00);
		rd(12'hF88, 8'h00);
		r = 8'($random(seed));
		wr(12'hF86, r);
		rd(12'hF86, r);
		wr(12'hF89, r);
		rd(12'hF89, 8'h00);
		for (i = 0; i < 3; i++) begin
			n = {8'h00, 1'b1, 1'($random(seed))};
			tx = (i == 2) ? 12'hDFE : 12'h300;
			rx = (i == 0) ? 12'hDFE : 12'h800;
			sspClkDiv <= 2'(i);
			go(2'(i), 8'h00);
			fin(2'(i));
		end
		n = 10'h009;
		go(2'h2, 8'h03);
		for (k = 0; k < 2000 && serialPortIrqFlag !== 1'b1; k++) @(posedge clk);
		chk(20'(transferActive), 20'h1);
		rd(12'hF80, 8'h03);
		fin(2'h2);
		sspMaster <= 1'b0;
		hold <= 1'b1;
		n = 10'h00F;
		ie = 1'b1;
		go(2'h2, 8'h50);
		wr(12'hF86, 8'h5F);
		rd(12'hF87, 8'h01);
		rd(12'hF80, 8'h0F);
		wr(12'hF87, 8'h00);
		rd(12'hF87, 8'h00);
		for (k = 0; k < 2000 && serialPortIrqFlag !== 1'b1; k++) @(posedge clk);
		chk(20'(k < 2000), 20'h1);
		chk(20'(transferActive), 20'h1);
		rd(12'hF80, 8'h0F);
		wr(12'hF87, 8'h00);
		hold <= 1'b0;
		fin(2'h2);
		repeat (4) @(posedge clk);
		end_of_test;
	end
endmodule // tb
`default_nettype wire
